//--- design/radio_deviation_state_config.sv
// Configuration bank for frequency deviation, post-transmit state, auto-calibration and power-on settling.
// Assumes the serial control decoder presents register accesses on this clock; oscStarted comes from analog.
`timescale 1ns/100ps
module radio_deviation_state_config #(
	parameter int EXPIRE_CYCLES = radio_cfg_pkg::EXPIRE_CYCLES
) (
	// Clock and reset
	input  wire logic                             clock,
	input  wire logic                             resetn,
	// Register port from serial control decoder
	input  wire logic [radio_cfg_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [7:0]                       regWriteData,
	input  wire logic                             regWrite,
	input  wire logic                             regRead,
	output logic [7:0]                            regReadData,
	// Modulator
	input  wire logic                             fskMode,
	input  wire logic                             txSymbol,
	output logic [radio_cfg_pkg::DEV_W-1:0]       freqOffset,
	// Radio state machine events
	input  wire logic                             packetDone,
	input  wire logic                             idleToTx,
	input  wire logic                             txToIdleAuto,
	input  wire logic                             manualCalibrateStrobe,
	output radio_cfg_pkg::post_state_t            postTxNextState,
	output logic                                  postTxNextValid,
	output logic                                  calibrateRequest,
	// Oscillator control and status
	input  wire logic                             sleepState,
	input  wire logic                             oscStarted,
	output logic                                  oscEnable,
	output logic                                  oscStableFlag,
	output logic                                  chipReady_n
);

	typedef struct packed {
		logic [7:0]                      deviation;
		logic [7:0]                      smCfgB;
		logic [7:0]                      smCfgA;
		logic [7:0]                      reserved20;
		logic [7:0]                      readData;
		logic [radio_cfg_pkg::DEV_W-1:0] offset;
		radio_cfg_pkg::post_state_t      nextState;
		logic                            nextValid;
		logic                            cal;
		logic [1:0]                      autoCount;
		logic                            oscEn;
		logic                            stable;
		logic                            readyN;
		logic                            startMeta;
		logic                            startSync;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic   settled;

	logic [2:0]  devExpFull;
	logic [3:0]  devMant4;
	logic [10:0] devMagnitude;
	logic [1:0]  postField;
	logic [1:0]  autocalField;
	logic [3:0]  wrSel;
	logic [3:0]  rdSel;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// One-hot register select; an unmapped address selects nothing, so writes there are dropped
	function automatic logic [3:0] reg_select(input logic [radio_cfg_pkg::ADDR_W-1:0] addr);
		case (addr)
			radio_cfg_pkg::ADDR_DEVIATION:  reg_select = 4'h1;
			radio_cfg_pkg::ADDR_SM_CFG_B:   reg_select = 4'h2;
			radio_cfg_pkg::ADDR_SM_CFG_A:   reg_select = 4'h4;
			radio_cfg_pkg::ADDR_RESERVED20: reg_select = 4'h8;
			default:                        reg_select = 4'h0;
		endcase
	endfunction

	assign wrSel = regWrite ? reg_select(regAddr) : 4'h0;
	assign rdSel = reg_select(regAddr);

	// ----------------------------------------------------------------
	// Settle counter
	// ----------------------------------------------------------------
	osc_settle_counter #(
		.EXPIRE_CYCLES (EXPIRE_CYCLES)
	) settleCounter (
		.clock        (clock),
		.resetn       (resetn),
		.oscRunning   (st_r.startSync),
		.settleSelect (st_r.smCfgA[radio_cfg_pkg::SETTLE_SEL_LSB +: 2]),
		.settled      (settled)
	);

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	assign devExpFull   = st_r.deviation[radio_cfg_pkg::DEV_E_LSB +: 3];
	assign devMant4     = {1'b1, st_r.deviation[radio_cfg_pkg::DEV_M_LSB +: 3]};
	// Exponent 7 with mantissa 15 fills all eleven bits
	// Deviation in crystal/2^17 steps
	assign devMagnitude = 11'(devMant4) << devExpFull;
	assign postField    = st_r.smCfgB[radio_cfg_pkg::POST_TX_LSB +: 2];
	assign autocalField = st_r.smCfgA[radio_cfg_pkg::AUTOCAL_LSB +: 2];

	always_comb begin
		st_nxt = st_r;

		// ------------------------------------------------------------
		// Register port
		// ------------------------------------------------------------
		// Unused bits masked on write
		if (wrSel[0])
			st_nxt.deviation  = regWriteData & radio_cfg_pkg::MASK_DEVIATION;
		if (wrSel[1])
			st_nxt.smCfgB     = regWriteData & radio_cfg_pkg::MASK_SM_CFG_B;
		if (wrSel[2])
			st_nxt.smCfgA     = regWriteData & radio_cfg_pkg::MASK_SM_CFG_A;
		if (wrSel[3])
			st_nxt.reserved20 = regWriteData & radio_cfg_pkg::MASK_RESERVED20;
		// Read data holds between reads; a write in the same cycle is not yet visible
		if (regRead) begin
			st_nxt.readData = ({8{rdSel[0]}} & st_r.deviation)
			                | ({8{rdSel[1]}} & st_r.smCfgB)
			                | ({8{rdSel[2]}} & st_r.smCfgA)
			                | ({8{rdSel[3]}} & st_r.reserved20);
		end

		// ------------------------------------------------------------
		// Deviation
		// ------------------------------------------------------------
		// Down for zero, up for one
		if (!fskMode)
			st_nxt.offset = '0;
		else if (txSymbol)
			st_nxt.offset = {1'b0, devMagnitude};
		else
			st_nxt.offset = 12'(-{1'b0, devMagnitude});

		// ------------------------------------------------------------
		// Post-transmit state
		// ------------------------------------------------------------
		// State holds until the next packet; valid marks each update
		st_nxt.nextValid = packetDone;
		if (packetDone) begin
			case (postField)
				radio_cfg_pkg::POST_TX_SYNTH_ON: st_nxt.nextState = radio_cfg_pkg::NEXT_SYNTH_ON;
				radio_cfg_pkg::POST_TX_STAY:     st_nxt.nextState = radio_cfg_pkg::NEXT_TX_PREAMBLE;
				default:                         st_nxt.nextState = radio_cfg_pkg::NEXT_IDLE;
			endcase
		end

		// ------------------------------------------------------------
		// Calibration
		// ------------------------------------------------------------
		// Calibration trigger select
		st_nxt.cal = manualCalibrateStrobe;
		case (autocalField)
			radio_cfg_pkg::CAL_FROM_IDLE: begin
				if (idleToTx)
					st_nxt.cal = 1'b1;
			end
			radio_cfg_pkg::CAL_TO_IDLE: begin
				if (txToIdleAuto)
					st_nxt.cal = 1'b1;
			end
			radio_cfg_pkg::CAL_EVERY_FOURTH: begin
				if (txToIdleAuto) begin
					// Count survives setting changes; only returns in this setting advance it
					st_nxt.autoCount = st_r.autoCount + 1'b1;
					if (st_r.autoCount == radio_cfg_pkg::CAL_FOURTH_COUNT)
						st_nxt.cal = 1'b1;
				end
			end
			default: ;
		endcase

		// ------------------------------------------------------------
		// Oscillator
		// ------------------------------------------------------------
		// Keep running in sleep
		st_nxt.oscEn     = !sleepState || st_r.smCfgA[radio_cfg_pkg::KEEP_OSC_BIT];
		// Two flops: the oscillator start comes from the analog side
		st_nxt.startMeta = oscStarted;
		st_nxt.startSync = st_r.startMeta;
		st_nxt.stable    = settled;
		st_nxt.readyN    = !settled;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// Outputs leave reset idle: oscillator on, chip not ready
			st_r            <= '0;
			st_r.deviation  <= radio_cfg_pkg::RST_DEVIATION;
			st_r.smCfgB     <= radio_cfg_pkg::RST_SM_CFG_B;
			st_r.smCfgA     <= radio_cfg_pkg::RST_SM_CFG_A;
			st_r.reserved20 <= radio_cfg_pkg::RST_RESERVED20;
			st_r.nextState  <= radio_cfg_pkg::NEXT_IDLE;
			st_r.oscEn      <= 1'b1;
			st_r.readyN     <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regReadData      = st_r.readData;
	assign freqOffset       = st_r.offset;
	assign postTxNextState  = st_r.nextState;
	assign postTxNextValid  = st_r.nextValid;
	assign calibrateRequest = st_r.cal;
	assign oscEnable        = st_r.oscEn;
	assign oscStableFlag    = st_r.stable;
	assign chipReady_n      = st_r.readyN;

endmodule

//--- shared/radio_cfg_pkg.sv
// Constants, field layouts and types of the deviation / state-machine / power-on configuration bank.
// Assumes a single crystal-derived clock at 125 MHz and a register port fed by the serial control decoder.
package radio_cfg_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 6;
	localparam logic [5:0]  ADDR_DEVIATION  = 6'h15;
	localparam logic [5:0]  ADDR_SM_CFG_B   = 6'h17;
	localparam logic [5:0]  ADDR_SM_CFG_A   = 6'h18;
	localparam logic [5:0]  ADDR_RESERVED20 = 6'h20;

	localparam logic [7:0]  RST_DEVIATION   = 8'h47;
	localparam logic [7:0]  RST_SM_CFG_B    = 8'h30;
	localparam logic [7:0]  RST_SM_CFG_A    = 8'h04;
	localparam logic [7:0]  RST_RESERVED20  = 8'hf8;

	localparam logic [7:0]  MASK_DEVIATION  = 8'h77;
	localparam logic [7:0]  MASK_SM_CFG_B   = 8'h3f;
	localparam logic [7:0]  MASK_SM_CFG_A   = 8'h3f;
	localparam logic [7:0]  MASK_RESERVED20 = 8'hfb;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DEV_M_LSB      = 0;
	localparam int DEV_E_LSB      = 4;
	localparam int POST_TX_LSB    = 0;
	localparam int AUTOCAL_LSB    = 4;
	localparam int SETTLE_SEL_LSB = 2;
	localparam int KEEP_OSC_BIT   = 0;

	localparam logic [1:0] POST_TX_IDLE     = 2'h0;
	localparam logic [1:0] POST_TX_SYNTH_ON = 2'h1;
	localparam logic [1:0] POST_TX_STAY     = 2'h2;

	localparam logic [1:0] CAL_NEVER        = 2'h0;
	localparam logic [1:0] CAL_FROM_IDLE    = 2'h1;
	localparam logic [1:0] CAL_TO_IDLE      = 2'h2;
	localparam logic [1:0] CAL_EVERY_FOURTH = 2'h3;
	localparam logic [1:0] CAL_FOURTH_COUNT = 2'h3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS    = 8000;
	localparam int EXPIRE_TIME_PS   = 2300000;
	localparam int EXPIRE_CYCLES    = (EXPIRE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETTLE_W         = 9;
	localparam logic [8:0] SETTLE_COUNT_0 = 9'h001;
	localparam logic [8:0] SETTLE_COUNT_1 = 9'h010;
	localparam logic [8:0] SETTLE_COUNT_2 = 9'h040;
	localparam logic [8:0] SETTLE_COUNT_3 = 9'h100;

	localparam int DEV_W = 12;

	typedef enum logic [1:0] {
		NEXT_IDLE,
		NEXT_SYNTH_ON,
		NEXT_TX_PREAMBLE
	} post_state_t;

endpackage

//--- design/osc_settle_counter.sv
// Power-on settle counter: counts expirations of a fixed prescaler while the oscillator runs.
// Assumes oscRunning is already synchronised to clock.
`timescale 1ns/100ps
module osc_settle_counter #(
	parameter int EXPIRE_CYCLES = radio_cfg_pkg::EXPIRE_CYCLES,
	parameter int PRE_W         = $clog2(EXPIRE_CYCLES + 1)
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// Control
	input  wire logic       oscRunning,
	input  wire logic [1:0] settleSelect,
	// Result
	output logic            settled
);

	typedef struct packed {
		logic [PRE_W-1:0]                    pre;
		logic [radio_cfg_pkg::SETTLE_W-1:0]  expired;
		logic                                done;
	} settle_t;

	settle_t s_r;
	settle_t s_nxt;
	logic [radio_cfg_pkg::SETTLE_W-1:0] target;

	assign settled = s_r.done;

	always_comb begin
		case (settleSelect)
			2'h0:    target = radio_cfg_pkg::SETTLE_COUNT_0;
			2'h1:    target = radio_cfg_pkg::SETTLE_COUNT_1;
			2'h2:    target = radio_cfg_pkg::SETTLE_COUNT_2;
			default: target = radio_cfg_pkg::SETTLE_COUNT_3;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		if (!oscRunning) begin
			// Oscillator stopped: settling must start over
			s_nxt = '0;
		end else if (!s_r.done) begin
			if (s_r.pre == PRE_W'(EXPIRE_CYCLES - 1)) begin
				s_nxt.pre     = '0;
				s_nxt.expired = s_r.expired + 1'b1;
				if (s_nxt.expired >= target)
					s_nxt.done = 1'b1;
			end else begin
				s_nxt.pre = s_r.pre + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

endmodule

//--- test/radio_cfg_sva.sv
// Checker for the deviation / state-machine / power-on configuration bank.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module radio_cfg_sva #(
	parameter int EXPIRE_CYCLES = radio_cfg_pkg::EXPIRE_CYCLES
) (
	// Clock and reset
	input wire logic                             clock,
	input wire logic                             resetn,
	// Register port
	input wire logic [radio_cfg_pkg::ADDR_W-1:0] regAddr,
	input wire logic                             regRead,
	input wire logic [7:0]                       regReadData,
	// Modulator and events
	input wire logic                             fskMode,
	input wire logic                             txSymbol,
	input wire logic [radio_cfg_pkg::DEV_W-1:0]  freqOffset,
	input wire logic                             packetDone,
	input wire logic                             idleToTx,
	input wire logic                             txToIdleAuto,
	input wire logic                             manualCalibrateStrobe,
	input wire radio_cfg_pkg::post_state_t       postTxNextState,
	input wire logic                             postTxNextValid,
	input wire logic                             calibrateRequest,
	// Oscillator
	input wire logic                             sleepState,
	input wire logic                             oscStarted,
	input wire logic                             oscEnable,
	input wire logic                             oscStableFlag,
	input wire logic                             chipReady_n
);
	logic [15:0] upCnt_r;
	logic        anyEv_r;
	// Saturates so a long-running oscillator never wraps the count
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			upCnt_r <= '0;
			anyEv_r <= 1'b0;
		end else begin
			upCnt_r <= !oscStarted ? 16'h0 : (upCnt_r == 16'hffff ? upCnt_r : upCnt_r + 16'h1);
			anyEv_r <= manualCalibrateStrobe | idleToTx | txToIdleAuto;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_pkt; packetDone; endsequence
	sequence s_osc_lost; !oscStarted [*5]; endsequence

	chk_ready_pair: assert property (chipReady_n == !oscStableFlag)
		else $error("chip ready not inverse of stable flag");
	chk_offset_sign: assert property (fskMode |=> freqOffset != '0 && freqOffset[11] == !$past(txSymbol))
		else $error("offset sign or magnitude wrong");
	chk_offset_ook: assert property (!fskMode |=> freqOffset == '0)
		else $error("offset not zero outside frequency shift");
	chk_post_valid: assert property (s_pkt |=> postTxNextValid)
		else $error("no next state after packet");
	chk_state_hold: assert property (!postTxNextValid |-> $stable(postTxNextState))
		else $error("next state moved without packet");
	chk_cal_cause: assert property (calibrateRequest |-> anyEv_r)
		else $error("calibration without event");
	chk_osc_awake: assert property (!sleepState |=> oscEnable)
		else $error("oscillator off while awake");
	chk_osc_lost: assert property (s_osc_lost |=> !oscStableFlag)
		else $error("stable flag without oscillator");
	chk_settle_min: assert property ($rose(oscStableFlag) |-> upCnt_r >= 16'(EXPIRE_CYCLES))
		else $error("stable flag too early");
	chk_unmapped_zero: assert property (regRead && !(regAddr inside {6'h15, 6'h17, 6'h18, 6'h20})
		|=> regReadData == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind radio_deviation_state_config radio_cfg_sva #(.EXPIRE_CYCLES(EXPIRE_CYCLES)) chk (.clock, .resetn,
	.regAddr, .regRead, .regReadData, .fskMode, .txSymbol, .freqOffset, .packetDone, .idleToTx, .txToIdleAuto,
	.manualCalibrateStrobe, .postTxNextState, .postTxNextValid, .calibrateRequest, .sleepState, .oscStarted,
	.oscEnable, .oscStableFlag, .chipReady_n);

//--- test/host_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes callers enter a task just after a rising edge.
`timescale 1ns/100ps
module host_model (
	// Clock
	input wire logic                        clock,
	// Register port
	output logic [radio_cfg_pkg::ADDR_W-1:0] regAddr,
	output logic [7:0]                       regWriteData,
	output logic                             regWrite,
	output logic                             regRead,
	input wire logic [7:0]                   regReadData
);
	initial begin
		regAddr = '0;
		regWriteData = '0;
		regWrite = 1'b0;
		regRead = 1'b0;
	end
	// Idle lines show the inverse, so a stale copy is never mistaken for a request
	task automatic release_bus();
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~regAddr;
		regWriteData = ~regWriteData;
		@(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		regAddr = a;
		regWriteData = d;
		regWrite = 1'b1;
		@(posedge clock);
		#1;
		release_bus();
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		regAddr = a;
		regRead = 1'b1;
		@(posedge clock);
		#1;
		release_bus();
		d = regReadData;
	endtask
endmodule

//--- test/radio_deviation_state_config_test.sv
// Self-checking bench for the configuration bank against a register model.
// Assumes a shortened prescaler so all settle counts run quickly.
`timescale 1ns/100ps
module radio_deviation_state_config_test;
	localparam int EXP = 4;
	logic clock = 1'b0, resetn = 1'b0, fskMode = 1'b0, txSymbol = 1'b0, packetDone = 1'b0, idleToTx = 1'b0;
	logic txToIdleAuto = 1'b0, manualCalibrateStrobe = 1'b0, sleepState = 1'b0, oscStarted = 1'b0;
	logic [5:0] regAddr;
	logic [7:0] regWriteData, regReadData, rdat;
	logic regWrite, regRead, postTxNextValid, calibrateRequest, oscEnable, oscStableFlag, chipReady_n;
	logic [11:0] freqOffset;
	radio_cfg_pkg::post_state_t postTxNextState;
	int error_cnt = 0, checks = 0, calCnt = 0;
	int mdl[64], msk[64];
	logic [31:0] rnd = 32'h7def;
	always #4 clock = ~clock;
	radio_deviation_state_config #(.EXPIRE_CYCLES(EXP)) uut (.clock, .resetn, .regAddr, .regWriteData,
		.regWrite, .regRead, .regReadData, .fskMode, .txSymbol, .freqOffset, .packetDone, .idleToTx,
		.txToIdleAuto, .manualCalibrateStrobe, .postTxNextState, .postTxNextValid, .calibrateRequest,
		.sleepState, .oscStarted, .oscEnable, .oscStableFlag, .chipReady_n);
	host_model host (.clock, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic step();
		@(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.wr(a, d);
		mdl[a] = d & msk[a];
	endtask
	// Register reset values, as after any reset
	task automatic model_reset();
		mdl[6'h15] = 8'h47;
		mdl[6'h17] = 8'h30;
		mdl[6'h18] = 8'h04;
		mdl[6'h20] = 8'hf8;
	endtask
	initial begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		print_verdict();
	end
	initial begin
		logic [5:0] adr[6] = '{6'h15, 6'h17, 6'h18, 6'h20, 6'h16, 6'h3f};
		logic [11:0] mag;
		int ev, n, ex;
		logic expc;
		msk[6'h15] = 8'h77; msk[6'h17] = 8'h3f; msk[6'h18] = 8'h3f; msk[6'h20] = 8'hfb;
		model_reset();
		repeat (20) step();
		resetn = 1'b1;
		for (int i = 0; i < 18; i++) begin
			rnd = lfsr(rnd);
			if (i >= 6) wr(adr[rnd % 6], rnd[15:8]);
			host.rd(adr[i % 6], rdat);
			chk("read", 12'(mdl[adr[i % 6]]), 12'(rdat));
		end
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wr(6'h15, {1'b0, 3'(i), 1'b0, rnd[2:0]});
			mag = 12'((8 + rnd[2:0]) << i);
			for (int t = 0; t < 3; t++) begin
				fskMode = (t != 2);
				txSymbol = t[0];
				step();
				chk("freqOffset", t == 2 ? 12'h0 : (t[0] ? mag : -mag), freqOffset);
			end
		end
		for (int f = 0; f < 4; f++) begin
			wr(6'h17, 8'h30 | 8'(f));
			packetDone = 1'b1;
			step();
			packetDone = 1'b0;
			chk("postTxNextValid", 12'h1, 12'(postTxNextValid));
			chk("postTxNextState", f == 3 ? 12'h0 : 12'(f), 12'(postTxNextState));
		end
		for (int s = 0; s < 4; s++) begin
			wr(6'h18, 8'(s << 4) | 8'h04);
			for (int i = 0; i < 8; i++) begin
				rnd = lfsr(rnd);
				ev = (s == 3) ? 2 : int'(rnd % 3);
				{manualCalibrateStrobe, idleToTx, txToIdleAuto} = 3'b100 >> ev;
				expc = ev == 0 || (ev == 1 && s == 1) || (ev == 2 && (s == 2 || (s == 3 && calCnt == 3)));
				if (ev == 2 && s == 3) calCnt = (calCnt + 1) % 4;
				step();
				{manualCalibrateStrobe, idleToTx, txToIdleAuto} = 3'b000;
				chk("calibrateRequest", 12'(expc), 12'(calibrateRequest));
				step();
			end
		end
		sleepState = 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr(6'h18, 8'h04 | 8'(k));
			step();
			chk("oscEnable", 12'(k), 12'(oscEnable));
		end
		sleepState = 1'b0;
		for (int p = 0; p < 4; p++) begin
			oscStarted = 1'b0;
			wr(6'h18, 8'(p << 2));
			repeat (6) step();
			chk("oscStableFlag", 12'h0, 12'(oscStableFlag));
			oscStarted = 1'b1;
			n = 0;
			while (oscStableFlag !== 1'b1 && n < 2000) begin
				step();
				n++;
			end
			ex = 3 + EXP * (1 << (p == 0 ? 0 : 2 * p + 2));
			chk("settle", 12'(ex), (n >= ex - 2 && n <= ex + 2) ? 12'(ex) : 12'(n));
			chk("chipReady_n", 12'h0, 12'(chipReady_n));
		end
		// Mid-run reset with the oscillator still running: settling and registers restart
		resetn = 1'b0;
		step();
		chk("chipReady_n", 12'h1, 12'(chipReady_n));
		chk("oscStableFlag", 12'h0, 12'(oscStableFlag));
		resetn = 1'b1;
		model_reset();
		n = 0;
		while (oscStableFlag !== 1'b1 && n < 2000) begin
			step();
			n++;
		end
		ex = 3 + EXP * 16;
		chk("settle", 12'(ex), (n >= ex - 2 && n <= ex + 2) ? 12'(ex) : 12'(n));
		for (int i = 0; i < 4; i++) begin
			host.rd(adr[i], rdat);
			chk("read", 12'(mdl[adr[i]]), 12'(rdat));
		end
		print_verdict();
	end
endmodule
